// >>> rtl/gds_pkg.sv
// constants and types for the gate drive sequencer
package gds_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CMD_FILTER_NS = 40;
	localparam int unsigned CMD_FILTER_CYC = (CMD_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ISO_FAILSAFE_DELAY_NS = 20;
	localparam int unsigned ISO_FAILSAFE_DELAY_CYC = ISO_FAILSAFE_DELAY_NS / CLK_PERIOD_NS;

	// register offsets
	localparam logic [3:0] MODE_ONE_ADDR = 4'h0;
	localparam logic [3:0] MODE_TWO_ADDR = 4'h1;
	localparam logic [3:0] TIMING_ADDR = 4'h2;
	localparam logic [3:0] BLANK_ADDR = 4'h3;
	localparam logic [3:0] STATUS_ADDR = 4'h4;
	localparam logic [3:0] FAULT_ADDR = 4'h5;

	// mode_config_one fields
	localparam int unsigned M1_SOFT = 0;
	localparam int unsigned M1_TWO_LVL = 1;
	localparam int unsigned M1_CLAMP = 2;
	localparam int unsigned M1_FAST = 3;
	localparam logic [7:0] MODE_ONE_RST = 8'h05;
	// mode_config_two fields
	localparam int unsigned M2_ISO_EN = 0;
	localparam logic [7:0] MODE_TWO_RST = 8'h00;
	// timing register: deadtime [7:0], soft duration [15:8], validate [23:16]
	localparam logic [23:0] TIMING_RST = 24'h40_20_0a;
	localparam logic [7:0] BLANK_RST = 8'h10;
	localparam logic [3:0] CLAMP_FILTER_RST = 4'h4;

	typedef enum logic [2:0] {
		GDS_OFF = 3'b000,
		GDS_ON = 3'b001,
		GDS_REDUCED = 3'b011,
		GDS_SOFT = 3'b010,
		GDS_LATCHED = 3'b110
	} gds_state_e;

endpackage : gds_pkg

// >>> rtl/gds_sequencer.sv
// gate drive sequencing, interlock, fault turn-off and iso fail-safe override
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gds_sequencer
	import gds_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// commands
	input  wire logic        pwm_command,
	input  wire logic        opposite_leg_command,
	input  wire logic        failsafe_enable_n,
	input  wire logic        failsafe_gate_command,
	input  wire logic        iso_side_failsafe_input,
	// analog monitors
	input  wire logic        fault_detect,
	input  wire logic        gate_below_clamp_level,
	input  wire logic        supply_ok,
	// gate drive
	output logic             gate_pullup_driver,
	output logic             gate_pulldown_driver,
	output logic             soft_turnoff,
	output logic             reduced_level_active,
	output logic             miller_clamp,
	output logic             holdoff_clamp,
	output logic             desat_sense_enable,
	output logic             fault_alert_a,
	output logic             fault_alert_b
);

	logic [7:0]  mode_one_ff, nxt_mode_one;
	logic [7:0]  mode_two_ff, nxt_mode_two;
	logic [23:0] timing_ff, nxt_timing;
	logic [7:0]  blank_ff, nxt_blank;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        dt_fault_ff, nxt_dt_fault;
	logic        hc_fault_ff, nxt_hc_fault;

	logic [2:0]  filt_cnt_ff, nxt_filt_cnt;
	logic        cmd_ff, nxt_cmd;
	logic        alt_ff, nxt_alt;
	logic [7:0]  dt_cnt_ff, nxt_dt_cnt;
	gds_state_e  state_ff, nxt_state;
	logic [7:0]  tmr_ff, nxt_tmr;
	logic [1:0]  trips_ff, nxt_trips;
	logic [7:0]  blank_cnt_ff, nxt_blank_cnt;
	logic [3:0]  clamp_cnt_ff, nxt_clamp_cnt;
	logic        clamp_on_ff, nxt_clamp_on;
	logic        gh_ff, gl_ff, ssd_ff, red_ff, amc_ff, hold_ff, des_ff, ia_ff, ib_ff;
	logic        nxt_gh, nxt_gl, nxt_ssd, nxt_red, nxt_amc, nxt_hold, nxt_des, nxt_ia, nxt_ib;

	logic        iso_active;
	logic        cmd_rise;
	logic        alt_rise;
	logic        dt_done;
	logic [7:0]  soft_time;
	logic        hc_trip;
	logic [2:0]  status_state;

	assign iso_active = iso_side_failsafe_input & mode_two_ff[M2_ISO_EN];
	assign cmd_rise = nxt_cmd & ~cmd_ff;
	assign alt_rise = opposite_leg_command & ~alt_ff;
	// the falling edge cycle itself is not yet clear: the counter loads on it
	assign dt_done = (dt_cnt_ff == 8'h00) & ~opposite_leg_command & ~alt_ff;
	assign soft_time = mode_one_ff[M1_FAST] ? {1'b0, timing_ff[15:9]} : timing_ff[15:8];
	// a validated high-current fault, with or without soft turn-off
	assign hc_trip = (nxt_state == GDS_SOFT || nxt_state == GDS_LATCHED)
		&& (state_ff == GDS_ON || state_ff == GDS_REDUCED);
	assign status_state = iso_active ? GDS_OFF : state_ff;

	// registers and read path
	always_comb
	begin
		nxt_mode_one = mode_one_ff;
		nxt_mode_two = mode_two_ff;
		nxt_timing = timing_ff;
		nxt_blank = blank_ff;
		nxt_rdata = 32'h0000_0000;
		nxt_dt_fault = dt_fault_ff | (cmd_rise & opposite_leg_command);
		nxt_hc_fault = hc_fault_ff | hc_trip;
		if (reg_wr)
		begin
			case (reg_addr)
				MODE_ONE_ADDR: nxt_mode_one = reg_wdata[7:0];
				MODE_TWO_ADDR: nxt_mode_two = reg_wdata[7:0];
				TIMING_ADDR:   nxt_timing = reg_wdata[23:0];
				BLANK_ADDR:    nxt_blank = reg_wdata[7:0];
				FAULT_ADDR:
				begin
					// set wins over clear
					if (reg_wdata[0] && !(cmd_rise & opposite_leg_command))
						nxt_dt_fault = 1'b0;
					if (reg_wdata[1] && !hc_trip)
						nxt_hc_fault = 1'b0;
				end
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				MODE_ONE_ADDR: nxt_rdata = {24'h00_0000, mode_one_ff};
				MODE_TWO_ADDR: nxt_rdata = {24'h00_0000, mode_two_ff};
				TIMING_ADDR:   nxt_rdata = {8'h00, timing_ff};
				BLANK_ADDR:    nxt_rdata = {24'h00_0000, blank_ff};
				// hi-z shows as off in both the pull-up bit and the state field
				STATUS_ADDR:   nxt_rdata = {26'h000_0000, status_state, miller_clamp,
						iso_side_failsafe_input, gh_ff};
				FAULT_ADDR:    nxt_rdata = {30'h0000_0000, hc_fault_ff, dt_fault_ff};
				default:       nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	// command deglitch and opposite-leg deadtime
	always_comb
	begin
		nxt_filt_cnt = 3'h0;
		nxt_cmd = cmd_ff;
		if (pwm_command != cmd_ff)
		begin
			if (filt_cnt_ff == 3'(CMD_FILTER_CYC - 1))
				nxt_cmd = pwm_command;
			else
				nxt_filt_cnt = filt_cnt_ff + 3'h1;
		end
		nxt_alt = opposite_leg_command;
		nxt_dt_cnt = (dt_cnt_ff != 8'h00) ? dt_cnt_ff - 8'h01 : 8'h00;
		if (alt_ff && !opposite_leg_command)
			nxt_dt_cnt = timing_ff[7:0];
	end

	// gate state machine
	always_comb
	begin
		nxt_state = state_ff;
		nxt_tmr = (tmr_ff != 8'h00) ? tmr_ff - 8'h01 : 8'h00;
		nxt_trips = trips_ff;
		if (cmd_rise)
			nxt_trips = 2'h0;
		case (state_ff)
			GDS_OFF:
				if (nxt_cmd && dt_done && !dt_fault_ff)
					nxt_state = GDS_ON;
			GDS_ON:
				if (!nxt_cmd || alt_rise || opposite_leg_command)
					nxt_state = GDS_OFF;
				else if (fault_detect && des_ff)
				begin
					if (mode_one_ff[M1_TWO_LVL] && trips_ff == 2'h0)
					begin
						nxt_state = GDS_REDUCED;
						nxt_tmr = timing_ff[23:16];
						nxt_trips = 2'h1;
					end
					else
					begin
						nxt_state = mode_one_ff[M1_SOFT] ? GDS_SOFT : GDS_LATCHED;
						nxt_tmr = soft_time;
					end
				end
			GDS_REDUCED:
				if (!fault_detect)
					nxt_state = (nxt_cmd && dt_done) ? GDS_ON : GDS_OFF;
				else if (tmr_ff == 8'h00)
				begin
					nxt_state = mode_one_ff[M1_SOFT] ? GDS_SOFT : GDS_LATCHED;
					nxt_tmr = soft_time;
				end
			GDS_SOFT:
				if (tmr_ff == 8'h00 || gate_below_clamp_level)
					nxt_state = GDS_LATCHED;
			GDS_LATCHED:
				if (!hc_fault_ff && !nxt_cmd)
					nxt_state = GDS_OFF;
			default: nxt_state = GDS_OFF;
		endcase
	end

	// output stage with fail-safe priority
	always_comb
	begin
		nxt_blank_cnt = (blank_cnt_ff != 8'h00) ? blank_cnt_ff - 8'h01 : 8'h00;
		nxt_clamp_cnt = clamp_cnt_ff;
		nxt_clamp_on = clamp_on_ff;
		if (cmd_rise)
		begin
			nxt_clamp_on = 1'b0;
			nxt_clamp_cnt = 4'h0;
		end
		else if (!gh_ff && gate_below_clamp_level && mode_one_ff[M1_CLAMP])
		begin
			if (clamp_cnt_ff == CLAMP_FILTER_RST)
				nxt_clamp_on = 1'b1;
			else
				nxt_clamp_cnt = clamp_cnt_ff + 4'h1;
		end
		if (nxt_state == GDS_ON && state_ff == GDS_OFF)
			nxt_blank_cnt = blank_ff;
		nxt_gh = (nxt_state == GDS_ON);
		nxt_red = (nxt_state == GDS_REDUCED);
		nxt_ssd = (nxt_state == GDS_SOFT);
		nxt_gl = (nxt_state == GDS_OFF) || (nxt_state == GDS_LATCHED);
		nxt_amc = nxt_clamp_on & mode_one_ff[M1_CLAMP] & ~nxt_gh;
		nxt_des = (nxt_state == GDS_ON) && (nxt_blank_cnt == 8'h00);
		nxt_hold = ~supply_ok;
		nxt_ia = ~(dt_fault_ff | hc_fault_ff);
		nxt_ib = ~(dt_fault_ff | hc_fault_ff);
		if (!failsafe_enable_n)
		begin
			nxt_gh = failsafe_gate_command & ~hc_fault_ff;
			nxt_gl = ~nxt_gh;
			nxt_red = 1'b0;
			nxt_ssd = 1'b0;
		end
		if (iso_active)
		begin
			nxt_gh = 1'b0;
			nxt_gl = 1'b0;
			nxt_red = 1'b0;
			nxt_ssd = 1'b0;
			nxt_amc = 1'b0;
			nxt_hold = 1'b0;
			nxt_des = 1'b0;
		end
		if (iso_side_failsafe_input)
			nxt_ib = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_one_ff <= MODE_ONE_RST;
			mode_two_ff <= MODE_TWO_RST;
			timing_ff <= TIMING_RST;
			blank_ff <= BLANK_RST;
			rdata_ff <= 32'h0000_0000;
			dt_fault_ff <= 1'b0;
			hc_fault_ff <= 1'b0;
			filt_cnt_ff <= 3'h0;
			cmd_ff <= 1'b0;
			alt_ff <= 1'b1;
			dt_cnt_ff <= 8'h00;
			state_ff <= GDS_OFF;
			tmr_ff <= 8'h00;
			trips_ff <= 2'h0;
			blank_cnt_ff <= 8'h00;
			clamp_cnt_ff <= 4'h0;
			clamp_on_ff <= 1'b0;
			gh_ff <= 1'b0;
			gl_ff <= 1'b1;
			ssd_ff <= 1'b0;
			red_ff <= 1'b0;
			amc_ff <= 1'b0;
			hold_ff <= 1'b1;
			des_ff <= 1'b0;
			ia_ff <= 1'b1;
			ib_ff <= 1'b1;
		end
		else
		begin
			mode_one_ff <= nxt_mode_one;
			mode_two_ff <= nxt_mode_two;
			timing_ff <= nxt_timing;
			blank_ff <= nxt_blank;
			rdata_ff <= nxt_rdata;
			dt_fault_ff <= nxt_dt_fault;
			hc_fault_ff <= nxt_hc_fault;
			filt_cnt_ff <= nxt_filt_cnt;
			cmd_ff <= nxt_cmd;
			alt_ff <= nxt_alt;
			dt_cnt_ff <= nxt_dt_cnt;
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			trips_ff <= nxt_trips;
			blank_cnt_ff <= nxt_blank_cnt;
			clamp_cnt_ff <= nxt_clamp_cnt;
			clamp_on_ff <= nxt_clamp_on;
			gh_ff <= nxt_gh;
			gl_ff <= nxt_gl;
			ssd_ff <= nxt_ssd;
			red_ff <= nxt_red;
			amc_ff <= nxt_amc;
			hold_ff <= nxt_hold;
			des_ff <= nxt_des;
			ia_ff <= nxt_ia;
			ib_ff <= nxt_ib;
		end
	end

	assign reg_rdata = rdata_ff;
	assign gate_pullup_driver = gh_ff;
	assign gate_pulldown_driver = gl_ff;
	assign soft_turnoff = ssd_ff;
	assign reduced_level_active = red_ff;
	assign miller_clamp = amc_ff;
	assign holdoff_clamp = hold_ff;
	assign desat_sense_enable = des_ff;
	assign fault_alert_a = ia_ff;
	assign fault_alert_b = ib_ff;

	a_iso_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n)
		iso_active |=> !gate_pullup_driver && !gate_pulldown_driver && !soft_turnoff)
		else $error("iso override did not tri-state gate");
	a_iso_alert_b: assert property (@(posedge ref_clk) disable iff (!rst_n)
		iso_side_failsafe_input |=> !fault_alert_b)
		else $error("alert b not low under iso input");
	a_iso_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(iso_active) |-> ##[1:2] !gate_pullup_driver && !gate_pulldown_driver)
		else $error("hi-z not reached in time");
	a_iso_holdoff: assert property (@(posedge ref_clk) disable iff (!rst_n)
		iso_active && !supply_ok |=> !holdoff_clamp)
		else $error("holdoff active during iso override");
	a_iso_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!mode_two_ff[M2_ISO_EN] && !failsafe_enable_n && failsafe_gate_command
		&& !hc_fault_ff |=> gate_pullup_driver)
		else $error("disabled iso input changed gate");
	a_alt_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
		opposite_leg_command && failsafe_enable_n |=> ##1 !gate_pullup_driver)
		else $error("gate on while opposite leg high");
	a_alt_cut: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == GDS_ON && alt_rise |=> state_ff == GDS_OFF)
		else $error("no immediate turn-off on opposite rise");
	a_dt_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_rise && opposite_leg_command |=> dt_fault_ff)
		else $error("deadtime fault not latched");
	a_dt_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		alt_ff && !opposite_leg_command && failsafe_enable_n |=> !gate_pullup_driver)
		else $error("gate on at opposite leg falling edge");
	a_filter: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$changed(cmd_ff) |-> $past(pwm_command, 1) == cmd_ff && $past(pwm_command, 4) == cmd_ff)
		else $error("command passed without filtering");
	a_turnon_stage: assert property (@(posedge ref_clk) disable iff (!rst_n)
		nxt_state == GDS_ON && failsafe_enable_n && !iso_active |=> gate_pullup_driver
		&& !gate_pulldown_driver && !soft_turnoff && !reduced_level_active && !miller_clamp)
		else $error("turn-on stage not as required");
	a_blank_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == GDS_OFF && nxt_state == GDS_ON && blank_ff != 8'h00 |=> !desat_sense_enable)
		else $error("desat sensed inside blanking");
	a_turnoff: assert property (@(posedge ref_clk) disable iff (!rst_n)
		nxt_state == GDS_OFF && failsafe_enable_n && !iso_active |=> gate_pulldown_driver)
		else $error("pull-down not on when off");
	a_soft_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == GDS_SOFT && (tmr_ff == 8'h00 || gate_below_clamp_level)
		|=> state_ff == GDS_LATCHED)
		else $error("soft turn-off did not end");
	a_reduced_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == GDS_ON && fault_detect && des_ff && mode_one_ff[M1_TWO_LVL]
		&& trips_ff == 2'h0 && nxt_cmd && !opposite_leg_command && failsafe_enable_n
		&& !iso_active |=> reduced_level_active && !gate_pullup_driver)
		else $error("reduced level not applied on first trip");
	a_reduced_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == GDS_REDUCED && !fault_detect && nxt_cmd && dt_done |=> state_ff == GDS_ON)
		else $error("gate not restored after unconfirmed fault");
	a_second_trip: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == GDS_ON && trips_ff != 2'h0 && fault_detect && des_ff && nxt_cmd
		&& !opposite_leg_command |=> state_ff == GDS_SOFT || state_ff == GDS_LATCHED)
		else $error("second trip not validated");
	a_clamp_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_rise |=> !miller_clamp)
		else $error("clamp held past command rise");
	a_clamp_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!mode_one_ff[M1_CLAMP] |=> !miller_clamp)
		else $error("clamp on while disabled");
	a_hold_uv: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!supply_ok && !iso_active |=> holdoff_clamp)
		else $error("holdoff not active under low supply");
	a_trip_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_rise |=> trips_ff == 2'h0)
		else $error("trip count not cleared on rise");

endmodule : gds_sequencer
`default_nettype wire

// >>> testbench/gds_gate_model.sv
// gate node model driven by the sequencer's output stage
`timescale 1ns/1ps
`default_nettype none
module gds_gate_model
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// output stage
	input  wire logic gate_pullup_driver,
	input  wire logic gate_pulldown_driver,
	input  wire logic soft_turnoff,
	// gate sense
	output logic      gate_below_clamp_level
);
	logic [3:0] lvl_ff;
	logic [3:0] nxt_lvl;

	// one step a cycle; nothing outside drives the node, it floats when hi-z
	always_comb
	begin
		nxt_lvl = lvl_ff;
		if (gate_pullup_driver && lvl_ff != 4'hf)
			nxt_lvl = lvl_ff + 4'h1;
		else if ((gate_pulldown_driver || soft_turnoff) && lvl_ff != 4'h0)
			nxt_lvl = lvl_ff - 4'h1;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			lvl_ff <= 4'h0;
		else
			lvl_ff <= nxt_lvl;

	assign gate_below_clamp_level = lvl_ff < 4'h2;
endmodule : gds_gate_model
`default_nettype wire

// >>> testbench/gds_sequencer_test.sv
// self-checking bench for the gate drive sequencer
`timescale 1ns/1ps
`default_nettype none
module gds_sequencer_test
	import gds_pkg::*;
;
	localparam int PU = 0, PD = 1, CL = 2, RD = 3, DS = 4, AB = 5, HO = 6, SO = 7;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        pwm_command = 1'b0;
	logic        opposite_leg_command = 1'b0;
	logic        failsafe_enable_n = 1'b1;
	logic        failsafe_gate_command = 1'b0;
	logic        iso_side_failsafe_input = 1'b0;
	logic        fault_detect = 1'b0;
	logic        supply_ok = 1'b1;
	wire logic   gate_below_clamp_level;
	logic        gate_pullup_driver, gate_pulldown_driver, soft_turnoff;
	logic        reduced_level_active, miller_clamp, holdoff_clamp;
	logic        desat_sense_enable, fault_alert_a, fault_alert_b;
	int          fails = 0;
	int          check_count = 0;
	int          cyc = 0;
	wire logic [7:0] outs = {soft_turnoff, holdoff_clamp, fault_alert_b, desat_sense_enable,
		reduced_level_active, miller_clamp, gate_pulldown_driver, gate_pullup_driver};

	gds_sequencer u_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .pwm_command, .opposite_leg_command, .failsafe_enable_n,
		.failsafe_gate_command, .iso_side_failsafe_input, .fault_detect,
		.gate_below_clamp_level, .supply_ok, .gate_pullup_driver, .gate_pulldown_driver,
		.soft_turnoff, .reduced_level_active, .miller_clamp, .holdoff_clamp,
		.desat_sense_enable, .fault_alert_a, .fault_alert_b);

	gds_gate_model u_gate (.ref_clk, .rst_n, .gate_pullup_driver, .gate_pulldown_driver,
		.soft_turnoff, .gate_below_clamp_level);

	always #5 ref_clk = ~ref_clk;

	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic await(input int s, input logic v, input int n);
		for (int i = 0; i < n && outs[s] !== v; i++)
			@(posedge ref_clk) #1;
		chk(outs[s], v);
	endtask : await

	task automatic hold(input int s, input logic v, input int n);
		repeat (n)
		begin
			@(posedge ref_clk) #1;
			chk(outs[s], v);
		end
	endtask : hold

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, exp);
	endtask : rd

	initial
	begin
		repeat (8) @(posedge ref_clk);
		#1 chk(outs, 8'h62);
		@(posedge ref_clk) rst_n <= 1'b1;
		rd(MODE_ONE_ADDR, 32'h05, '1);
		rd(MODE_TWO_ADDR, 32'h00, '1);
		rd(TIMING_ADDR, 32'h40200a, '1);
		rd(BLANK_ADDR, 32'h10, '1);
		wr(4'hf, 32'hff);
		rd(4'hf, 32'h0, '1);
		@(posedge ref_clk) pwm_command <= 1'b1;
		await(PU, 1'b1, 12);
		chk(outs[3:0], 4'h1);
		chk(outs[DS], 1'b0);
		await(DS, 1'b1, 24);
		@(posedge ref_clk) pwm_command <= 1'b0;
		await(PD, 1'b1, 12);
		chk(outs[PU], 1'b0);
		await(CL, 1'b1, 30);
		hold(CL, 1'b1, 10);
		@(posedge ref_clk) pwm_command <= 1'b1;
		await(CL, 1'b0, 12);
		@(posedge ref_clk) pwm_command <= 1'b0;
		await(PD, 1'b1, 12);
		repeat (20) @(posedge ref_clk);
		pwm_command <= 1'b1;
		repeat (2) @(posedge ref_clk);
		pwm_command <= 1'b0;
		hold(PU, 1'b0, 15);
		wr(MODE_ONE_ADDR, 32'h01);
		@(posedge ref_clk) pwm_command <= 1'b1;
		await(PU, 1'b1, 12);
		@(posedge ref_clk) pwm_command <= 1'b0;
		hold(CL, 1'b0, 40);
		wr(TIMING_ADDR, 32'h40201e);
		@(posedge ref_clk) opposite_leg_command <= 1'b1;
		repeat (6) @(posedge ref_clk);
		pwm_command <= 1'b1;
		hold(PU, 1'b0, 20);
		rd(FAULT_ADDR, 32'h1, 32'h1);
		wr(FAULT_ADDR, 32'h1);
		rd(FAULT_ADDR, 32'h0, 32'h1);
		@(posedge ref_clk) opposite_leg_command <= 1'b0;
		hold(PU, 1'b0, 26);
		await(PU, 1'b1, 16);
		@(posedge ref_clk) opposite_leg_command <= 1'b1;
		await(PU, 1'b0, 8);
		@(posedge ref_clk);
		pwm_command <= 1'b0;
		opposite_leg_command <= 1'b0;
		repeat (40) @(posedge ref_clk);
		wr(MODE_ONE_ADDR, 32'h03);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge ref_clk) pwm_command <= 1'b1;
			await(DS, 1'b1, 40);
			@(posedge ref_clk) fault_detect <= 1'b1;
			await(RD, 1'b1, 8);
			chk(outs[PU], 1'b0);
			@(posedge ref_clk) fault_detect <= 1'b0;
			await(RD, 1'b0, 40);
			chk(outs[PU], 1'b1);
			if (k == 1)
			begin
				@(posedge ref_clk) fault_detect <= 1'b1;
				await(SO, 1'b1, 8);
				chk(outs[PU], 1'b0);
				@(posedge ref_clk) fault_detect <= 1'b0;
				rd(FAULT_ADDR, 32'h2, 32'h2);
				chk(fault_alert_a, 1'b0);
				await(SO, 1'b0, 44);
			end
			@(posedge ref_clk) pwm_command <= 1'b0;
			await(PD, 1'b1, 12);
		end
		wr(FAULT_ADDR, 32'h3);
		@(posedge ref_clk) iso_side_failsafe_input <= 1'b1;
		hold(PD, 1'b1, 10);
		@(posedge ref_clk) iso_side_failsafe_input <= 1'b0;
		wr(MODE_TWO_ADDR, 32'h1);
		@(posedge ref_clk) pwm_command <= 1'b1;
		await(PU, 1'b1, 12);
		@(posedge ref_clk);
		iso_side_failsafe_input <= 1'b1;
		failsafe_enable_n <= 1'b0;
		failsafe_gate_command <= 1'b1;
		supply_ok <= 1'b0;
		await(PU, 1'b0, ISO_FAILSAFE_DELAY_CYC + 2);
		hold(PD, 1'b0, 10);
		chk(outs[AB], 1'b0);
		chk(outs[HO], 1'b0);
		chk(fault_alert_a, 1'b1);
		rd(STATUS_ADDR, 32'h2, 32'h3b);
		@(posedge ref_clk) iso_side_failsafe_input <= 1'b0;
		await(HO, 1'b1, 6);
		wr(MODE_TWO_ADDR, 32'h0);
		@(posedge ref_clk) iso_side_failsafe_input <= 1'b1;
		hold(PU, 1'b1, 4);
		chk(outs[AB], 1'b0);
		close_out();
	end
endmodule : gds_sequencer_test
`default_nettype wire
